// file: rtl/crsc_params.svh
// Register offsets, field positions, reset values and codes of the
// conversion result and scan control block.
// Assumes inclusion by bare name from every file that needs it.
`ifndef CRSC_PARAMS_SVH
`define CRSC_PARAMS_SVH

`define CRSC_ADDR_W          7
`define CRSC_ADDR_AUX        7'h12
`define CRSC_ADDR_DONE       7'h18
`define CRSC_ADDR_RES_HIGH   7'h1a
`define CRSC_ADDR_RES_LOW    7'h1b
`define CRSC_ADDR_STATUS     7'h1e
`define CRSC_ADDR_SCAN       7'h1f

`define CRSC_CUR_MSB         3
`define CRSC_CUR_LSB         0
`define CRSC_CUR_RESET       4'h0
`define CRSC_CUR_MAX         4'ha
`define CRSC_CUR_STEP_UA     11'h064

`define CRSC_DONE_EMPTY      8'hff
`define CRSC_DONE_READY      8'h00

`define CRSC_STS_PENDING_BIT 1
`define CRSC_STS_STALE_BIT   0

`define CRSC_MODE_MSB        7
`define CRSC_MODE_LSB        6
`define CRSC_LAST_MSB        5
`define CRSC_LAST_LSB        3
`define CRSC_FIRST_MSB       2
`define CRSC_FIRST_LSB       0
`define CRSC_MODE_RESET      2'h0
`define CRSC_LAST_RESET      3'h6
`define CRSC_FIRST_RESET     3'h0
`define CRSC_SLOT_REJECT     3'h7

`define CRSC_MODE_SINGLE     2'h0
`define CRSC_MODE_ONCE       2'h1
`define CRSC_MODE_LOOP       2'h2
`define CRSC_MODE_BURNOUT    2'h3

`endif

// file: rtl/crsc_pkg.sv
// Types shared by the conversion result and scan control block.
// Assumes nothing of its surroundings.
package crsc_pkg;

    typedef logic [7:0]  crsc_byte_t;
    typedef logic [2:0]  crsc_slot_t;
    typedef logic [1:0]  crsc_mode_t;
    typedef logic [15:0] crsc_result_t;
    typedef logic [10:0] crsc_ua_t;

    typedef enum logic [0:0]
    {
        CRSC_IDLE,
        CRSC_RUN
    } crsc_state_t;

endpackage

// file: rtl/crsc_seq_if.sv
// Link between the register file and the channel sequencer.
// Assumes both ends run on the same clock.
`timescale 1ns/10ps

interface crsc_seq_if;
    import crsc_pkg::*;

    logic       load;
    crsc_mode_t mode;
    crsc_slot_t first;
    crsc_slot_t last;
    logic       pending;
    logic       running;
    logic       burnout;
    crsc_slot_t slot;

    modport regs
    (
        output load,
        output mode,
        output first,
        output last,
        input  pending,
        input  running,
        input  burnout,
        input  slot
    );

    modport seq
    (
        input  load,
        input  mode,
        input  first,
        input  last,
        output pending,
        output running,
        output burnout,
        output slot
    );

endinterface

// file: rtl/crsc_seq.sv
// Channel sequencer: holds the staged and the active scan setup and
// steps the converted channel at each conversion boundary.
// Assumes conv_done is a one-cycle pulse at the end of each conversion.
`timescale 1ns/10ps
`include "crsc_params.svh"

module crsc_seq
(
    input  wire logic  sys_clk,
    input  wire logic  resetn,
    input  wire logic  conv_done,
    crsc_seq_if.seq    bus
);
    import crsc_pkg::*;

    crsc_mode_t  shadow_mode_reg;
    crsc_slot_t  shadow_first_reg;
    crsc_slot_t  shadow_last_reg;
    crsc_mode_t  act_mode_reg;
    crsc_slot_t  act_first_reg;
    crsc_slot_t  act_last_reg;
    logic        pending_reg;
    logic        pending_next;
    crsc_state_t state_reg;
    crsc_state_t state_next;
    crsc_slot_t  slot_reg;
    crsc_slot_t  slot_next;
    logic        burnout_reg;
    logic        burnout_next;
    logic        apply;
    logic        at_last;
    crsc_slot_t  slot_inc;

    // A staged setup takes effect between conversions, never inside one.
    assign apply    = pending_reg && (conv_done || state_reg == CRSC_IDLE);
    assign at_last  = slot_reg == act_last_reg;
    assign slot_inc = slot_reg + 3'h1;
    // Set wins: a load beside an apply keeps the flag high.
    assign pending_next = bus.load || (pending_reg && !apply);

    always_comb
    begin
        state_next = state_reg;
        slot_next  = slot_reg;
        if (apply)
        begin
            state_next = CRSC_RUN;
            slot_next  = shadow_first_reg;
        end
        else if (conv_done && state_reg == CRSC_RUN)
        begin
            case (act_mode_reg)
                `CRSC_MODE_SINGLE:
                    slot_next = act_first_reg;
                `CRSC_MODE_ONCE:
                    if (at_last)
                        state_next = CRSC_IDLE;
                    else
                        slot_next = slot_inc;
                default:
                    slot_next = at_last ? act_first_reg : slot_inc;
            endcase
        end
        burnout_next = state_next == CRSC_RUN &&
                       (apply ? shadow_mode_reg : act_mode_reg) ==
                       `CRSC_MODE_BURNOUT;
    end

    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            shadow_mode_reg  <= `CRSC_MODE_RESET;
            shadow_first_reg <= `CRSC_FIRST_RESET;
            shadow_last_reg  <= `CRSC_LAST_RESET;
            act_mode_reg     <= `CRSC_MODE_RESET;
            act_first_reg    <= `CRSC_FIRST_RESET;
            act_last_reg     <= `CRSC_LAST_RESET;
            pending_reg      <= 1'b0;
            state_reg        <= CRSC_RUN;
            slot_reg         <= `CRSC_FIRST_RESET;
            burnout_reg      <= 1'b0;
        end
        else
        begin
            if (bus.load)
            begin
                shadow_mode_reg  <= bus.mode;
                shadow_first_reg <= bus.first;
                shadow_last_reg  <= bus.last;
            end
            if (apply)
            begin
                act_mode_reg  <= shadow_mode_reg;
                act_first_reg <= shadow_first_reg;
                act_last_reg  <= shadow_last_reg;
            end
            pending_reg <= pending_next;
            state_reg   <= state_next;
            slot_reg    <= slot_next;
            burnout_reg <= burnout_next;
        end
    end

    assign bus.pending = pending_reg;
    assign bus.running = state_reg == CRSC_RUN;
    assign bus.burnout = burnout_reg;
    assign bus.slot    = slot_reg;

endmodule

// file: rtl/crsc_top.sv
// Register bank of the conversion result and scan control block:
// excitation current select, result bytes with freshness tracking,
// sequencer status and the scan setup register with write rejection.
// Assumes a register port master that keeps strobes one cycle long and
// a converter that pulses conv_done with conv_result at each result.
`timescale 1ns/10ps
`include "crsc_params.svh"

// Summary of operation
// - Excitation current equals code times 100 uA up to code 10, zero above; reset code is zero.
// - Data-available byte reads 0xff when no fresh result, else 0x00.
// - Result is 16-bit two's complement; high at 0x1a, low at 0x1b.
// - Status bit 1 high while scan update pending; host waits for low.
// - Status bit 0 high when result read was stale or not ready.
// - Two-bit mode: single channel, single scan, loop, loop with burnout.
// - Final-channel field picks last scanned channel; resets to six.
// - Initial-channel field picks first scanned channel; resets to zero.
// - Scan write carrying seven in a channel field is wholly discarded.
module crsc_top
#(
    parameter int NUM_SLOTS = 7
)
(
    input  wire logic                 sys_clk,
    input  wire logic                 resetn,
    input  wire logic [6:0]           reg_addr,
    input  wire crsc_pkg::crsc_byte_t reg_wdata,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    output crsc_pkg::crsc_byte_t      reg_rdata,
    input  wire logic                 conv_done,
    input  wire crsc_pkg::crsc_result_t conv_result,
    output logic                      conv_run,
    output crsc_pkg::crsc_slot_t      conv_slot,
    output logic                      burnout_en,
    output logic [3:0]                excitation_current_code,
    output crsc_pkg::crsc_ua_t        excitation_current_ua
);
    import crsc_pkg::*;

    if (NUM_SLOTS < 1 || NUM_SLOTS > 7)
    begin : g_bad_slots
        $error("NUM_SLOTS must lie between 1 and 7");
    end

    localparam crsc_slot_t SLOT_LIMIT = crsc_slot_t'(NUM_SLOTS);

    // Converts a current code to microamps; codes above the top step
    // are treated as off so the source is never overdriven.
    function automatic crsc_ua_t crsc_code_to_ua(input logic [3:0] code);
        crsc_ua_t ua;
        ua = 11'h000;
        if (code <= `CRSC_CUR_MAX)
            ua = crsc_ua_t'({7'h00, code} * `CRSC_CUR_STEP_UA);
        return ua;
    endfunction

    // Tells whether a channel field names a channel that exists.
    function automatic logic crsc_slot_ok(input crsc_slot_t s);
        return s != `CRSC_SLOT_REJECT && s < SLOT_LIMIT;
    endfunction

    crsc_seq_if seq_bus ();

    logic [3:0]   cur_reg;
    logic [3:0]   cur_next;
    crsc_ua_t     ua_reg;
    crsc_ua_t     ua_next;
    crsc_result_t result_reg;
    crsc_result_t result_next;
    logic         fresh_reg;
    logic         fresh_next;
    logic         stale_reg;
    logic         stale_next;
    crsc_mode_t   mode_reg;
    crsc_slot_t   last_reg;
    crsc_slot_t   first_reg;
    crsc_byte_t   rdata_reg;
    crsc_byte_t   rdata_next;
    crsc_byte_t   rd_mux;

    wire       sel_aux    = reg_addr == `CRSC_ADDR_AUX;
    wire       sel_done   = reg_addr == `CRSC_ADDR_DONE;
    wire       sel_high   = reg_addr == `CRSC_ADDR_RES_HIGH;
    wire       sel_low    = reg_addr == `CRSC_ADDR_RES_LOW;
    wire       sel_status = reg_addr == `CRSC_ADDR_STATUS;
    wire       sel_scan   = reg_addr == `CRSC_ADDR_SCAN;

    wire       wr_aux     = reg_wr && sel_aux;
    wire       wr_scan    = reg_wr && sel_scan;
    wire       rd_high    = reg_rd && sel_high;
    wire       rd_low     = reg_rd && sel_low;
    wire       rd_result  = rd_high || rd_low;

    wire crsc_mode_t wr_mode  = reg_wdata[`CRSC_MODE_MSB:`CRSC_MODE_LSB];
    wire crsc_slot_t wr_last  = reg_wdata[`CRSC_LAST_MSB:`CRSC_LAST_LSB];
    wire crsc_slot_t wr_first = reg_wdata[`CRSC_FIRST_MSB:`CRSC_FIRST_LSB];

    // A scan write is taken only when both channel fields are legal and
    // no earlier update is still waiting for a conversion boundary.
    wire       scan_fields_ok = crsc_slot_ok(wr_first) &&
                                crsc_slot_ok(wr_last);
    wire       scan_accept    = wr_scan && scan_fields_ok &&
                                !seq_bus.pending;

    // The range check relies on the host keeping final at or above
    // initial; a reversed range simply runs until the counter meets it.
    assign seq_bus.load  = scan_accept;
    assign seq_bus.mode  = wr_mode;
    assign seq_bus.last  = wr_last;
    assign seq_bus.first = wr_first;

    crsc_seq u_seq
    (
        .sys_clk   (sys_clk),
        .resetn    (resetn),
        .conv_done (conv_done),
        .bus       (seq_bus)
    );

    assign cur_next = wr_aux ? reg_wdata[`CRSC_CUR_MSB:`CRSC_CUR_LSB]
                             : cur_reg;
    assign ua_next  = wr_aux ? crsc_code_to_ua(cur_next) : ua_reg;

    // A new result both loads the value and marks it fresh; a read of
    // the low byte in the same cycle must not wipe out that mark.
    assign result_next = conv_done ? conv_result : result_reg;
    assign fresh_next  = conv_done || (fresh_reg && !rd_low);

    // Every result byte read reports on the value it actually returned.
    assign stale_next  = rd_result ? !fresh_reg : stale_reg;

    always_comb
    begin
        rd_mux = 8'h00;
        case (1'b1)
            sel_aux:
                rd_mux = {4'h0, cur_reg};
            sel_done:
                rd_mux = fresh_reg ? `CRSC_DONE_READY
                                   : `CRSC_DONE_EMPTY;
            sel_high:
                rd_mux = result_reg[15:8];
            sel_low:
                rd_mux = result_reg[7:0];
            sel_status:
            begin
                rd_mux[`CRSC_STS_PENDING_BIT] = seq_bus.pending;
                rd_mux[`CRSC_STS_STALE_BIT]   = stale_reg;
            end
            sel_scan:
                rd_mux = {mode_reg, last_reg, first_reg};
            default:
                rd_mux = 8'h00;
        endcase
    end

    // Read data stand only in the cycle after the strobe, zero otherwise.
    assign rdata_next = reg_rd ? rd_mux : 8'h00;

    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            cur_reg <= `CRSC_CUR_RESET;
            ua_reg  <= 11'h000;
        end
        else
        begin
            cur_reg <= cur_next;
            ua_reg  <= ua_next;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            result_reg <= 16'h0000;
            fresh_reg  <= 1'b0;
            stale_reg  <= 1'b0;
        end
        else
        begin
            result_reg <= result_next;
            fresh_reg  <= fresh_next;
            stale_reg  <= stale_next;
        end
    end

    // Readback copy of the last accepted scan setup.
    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            mode_reg  <= `CRSC_MODE_RESET;
            last_reg  <= `CRSC_LAST_RESET;
            first_reg <= `CRSC_FIRST_RESET;
        end
        else if (scan_accept)
        begin
            mode_reg  <= wr_mode;
            last_reg  <= wr_last;
            first_reg <= wr_first;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
            rdata_reg <= 8'h00;
        else
            rdata_reg <= rdata_next;
    end

    assign reg_rdata               = rdata_reg;
    assign conv_run                = seq_bus.running;
    assign conv_slot               = seq_bus.slot;
    assign burnout_en              = seq_bus.burnout;
    assign excitation_current_code = cur_reg;
    assign excitation_current_ua   = ua_reg;

endmodule

// file: verif/crsc_top_asserts.sv
// Port-level checks of crsc_top, bound into every instance.
// Assumes one clock and the synchronous active-low reset.
`timescale 1ns/10ps

module crsc_checker
#(
    parameter int NUM_SLOTS = 7
)
(
    input wire logic                   sys_clk,
    input wire logic                   resetn,
    input wire logic [6:0]             reg_addr,
    input wire crsc_pkg::crsc_byte_t   reg_wdata,
    input wire logic                   reg_wr,
    input wire logic                   reg_rd,
    input wire crsc_pkg::crsc_byte_t   reg_rdata,
    input wire logic                   conv_done,
    input wire crsc_pkg::crsc_result_t conv_result,
    input wire logic                   conv_run,
    input wire crsc_pkg::crsc_slot_t   conv_slot,
    input wire logic                   burnout_en,
    input wire logic [3:0]             excitation_current_code,
    input wire crsc_pkg::crsc_ua_t     excitation_current_ua
);
    import crsc_pkg::*;
    crsc_result_t res_reg;
    logic         have_reg;
    wire logic    rd_hi = reg_rd && reg_addr == 7'h1a && !conv_done;
    wire logic    rd_lo = reg_rd && reg_addr == 7'h1b && !conv_done;
    wire logic    rd_scan = reg_rd && reg_addr == 7'h1f;
    wire logic    rej = reg_wr && reg_addr == 7'h1f &&
        (reg_wdata[2:0] == 3'h7 || reg_wdata[5:3] == 3'h7);

    always_ff @(posedge sys_clk)
    begin
        have_reg <= resetn && (have_reg || conv_done);
        if (conv_done)
            res_reg <= conv_result;
    end

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!resetn);

    property p_reject;
        crsc_byte_t v;
        rd_scan ##1 (rej, v = reg_rdata) ##1 rd_scan |=> reg_rdata == v;
    endproperty

    a_current_scale:
        assert property ($stable(excitation_current_code) |->
            excitation_current_ua == (excitation_current_code <= 4'ha ?
            {7'h00, excitation_current_code} * 11'h064 : 11'h000))
        else $error("current output mismatch");
    a_rdata_quiet:
        assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside read cycle");
    a_done_fresh:
        assert property (conv_done ##1 (reg_rd && reg_addr == 7'h18)
            |=> reg_rdata == 8'h00)
        else $error("data available not shown");
    a_high_byte:
        assert property (have_reg && rd_hi |=> reg_rdata == res_reg[15:8])
        else $error("upper result byte wrong");
    a_low_byte:
        assert property (have_reg && rd_lo |=> reg_rdata == res_reg[7:0])
        else $error("lower result byte wrong");
    a_scan_reject:
        assert property (p_reject)
        else $error("rejected scan write changed register");
    a_slot_range:
        assert property (conv_slot < 3'(NUM_SLOTS))
        else $error("channel out of range");
    a_slot_cause:
        assert property ($changed(conv_slot) |->
            $past(conv_done) || $past(reg_wr, 2))
        else $error("channel moved without cause");
    a_run_stop:
        assert property ($fell(conv_run) |-> $past(conv_done))
        else $error("run dropped without conversion");
    a_burn_run:
        assert property (burnout_en |-> conv_run)
        else $error("burnout while stopped");

    c_reject: cover property (rej);
    c_stop: cover property ($fell(conv_run));
    c_burn: cover property (burnout_en);
endmodule

bind crsc_top crsc_checker #(.NUM_SLOTS(NUM_SLOTS)) u_crsc_checker
(
    .sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .conv_done(conv_done),
    .conv_result(conv_result), .conv_run(conv_run),
    .conv_slot(conv_slot), .burnout_en(burnout_en),
    .excitation_current_code(excitation_current_code),
    .excitation_current_ua(excitation_current_ua)
);

// file: verif/crsc_host.sv
// Host side of the register port: bus cycles and host duties.
// Assumes tasks are entered just after a rising clock edge.
`timescale 1ns/10ps

module crsc_host
(
    input  wire logic                 sys_clk,
    input  wire crsc_pkg::crsc_byte_t reg_rdata,
    output logic [6:0]                reg_addr,
    output crsc_pkg::crsc_byte_t      reg_wdata,
    output logic                      reg_wr,
    output logic                      reg_rd
);
    import crsc_pkg::*;
    realtime last_rd [2] = '{-1.0e6, -1.0e6};
    int      timeouts = 0;

    initial
    begin
        reg_addr = 7'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end

    task automatic rd(input logic [6:0] a, output crsc_byte_t d);
        // Repeated result byte reads keep a 72 us spacing.
        while ((a == 7'h1a || a == 7'h1b) &&
            $realtime - last_rd[a[0]] < 72000.0)
        begin
            @(posedge sys_clk);
            #1;
        end
        if (a == 7'h1a || a == 7'h1b)
            last_rd[a[0]] = $realtime;
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask

    task automatic wr(input logic [6:0] a, input crsc_byte_t d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        #1;
    endtask

    task automatic wr_scan(input crsc_byte_t d);
        crsc_byte_t s;
        int         n;
        s = 8'h02;
        n = 0;
        while (s[1] && n < 50)
        begin
            rd(7'h1e, s);
            n++;
        end
        if (s[1])
            timeouts++;
        wr(7'h1f, d);
    endtask
endmodule

// file: verif/test_conversion_result_scan_control.sv
// Self-checking bench of the conversion result and scan control block.
// Assumes crsc_top, the host model and the bound checker.
`timescale 1ns/10ps

module test_conversion_result_scan_control;
    import crsc_pkg::*;
    logic         sys_clk = 1'b0;
    logic         resetn = 1'b0;
    logic [6:0]   reg_addr;
    crsc_byte_t   reg_wdata;
    logic         reg_wr;
    logic         reg_rd;
    crsc_byte_t   reg_rdata;
    logic         conv_done = 1'b0;
    crsc_result_t conv_result = 16'h0000;
    logic         conv_run;
    crsc_slot_t   conv_slot;
    logic         burnout_en;
    logic [3:0]   cur_code;
    crsc_ua_t     cur_ua;
    crsc_byte_t   d;
    int mismatches = 0;
    int n_tests = 0;
    int seed = 32'h824aec5c;
    int res = 0, fresh = 0, stale = 0, pend = 0, cur = 0, scan = 8'h30;
    int act = 8'h30, slot = 0, run = 1, i, j, f, l;

    crsc_top u_crsc_top
    (
        .sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .conv_done(conv_done),
        .conv_result(conv_result), .conv_run(conv_run),
        .conv_slot(conv_slot), .burnout_en(burnout_en),
        .excitation_current_code(cur_code),
        .excitation_current_ua(cur_ua)
    );

    crsc_host host
    (
        .sys_clk(sys_clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd)
    );

    initial
    begin
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic check(input string what, input logic [15:0] e, g);
        n_tests++;
        if (g !== e)
        begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", what, e, g);
        end
    endtask

    task automatic rd_chk(input logic [6:0] a);
        logic [7:0] e;
        case (a)
            7'h12: e = 8'(cur);
            7'h18: e = fresh ? 8'h00 : 8'hff;
            7'h1a: e = 8'(res >> 8);
            7'h1b: e = 8'(res);
            7'h1e: e = 8'(pend * 2 + stale);
            7'h1f: e = 8'(scan);
            default: e = 8'h00;
        endcase
        if (a == 7'h1a || a == 7'h1b)
            stale = !fresh;
        if (a == 7'h1b)
            fresh = 0;
        host.rd(a, d);
        check($sformatf("read of %h", a), {8'h00, e}, {8'h00, d});
    endtask

    task automatic out_chk;
        check("channel", 16'(slot), {13'h0, conv_slot});
        check("run", 16'(run), {15'h0, conv_run});
        check("burnout", 16'(run && act[7:6] == 3),
              {15'h0, burnout_en});
    endtask

    task automatic apply;
        act = scan;
        slot = act[2:0];
        run = 1;
        pend = 0;
    endtask

    task automatic conv(input logic [15:0] v);
        conv_result <= v;
        conv_done <= 1'b1;
        @(posedge sys_clk);
        conv_done <= 1'b0;
        #1;
        res = v;
        fresh = 1;
        if (pend)
            apply();
        else if (run && act[7:6] != 0 && slot != act[5:3])
            slot++;
        else if (run && act[7:6] == 1)
            run = 0;
        else if (run && act[7:6] != 0)
            slot = act[2:0];
        out_chk();
    endtask

    task automatic summarize;
        mismatches += host.timeouts;
        $display("checks %0d, mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial
    begin
        #1000000;
        mismatches++;
        summarize();
    end

    initial
    begin
        repeat (5) @(posedge sys_clk);
        resetn <= 1'b1;
        @(posedge sys_clk);
        #1;
        out_chk();
        host.wr(7'h1c, 8'hff);
        rd_chk(7'h12);
        rd_chk(7'h1c);
        rd_chk(7'h18);
        rd_chk(7'h1e);
        rd_chk(7'h1f);
        for (i = 0; i < 16; i++)
        begin
            d = 8'($random(seed));
            host.wr(7'h12, {d[7:4], i[3:0]});
            cur = i;
            @(posedge sys_clk);
            #1;
            check("code", 16'(i), {12'h0, cur_code});
            check("ua", 16'(i <= 10 ? i * 100 : 0), {5'h0, cur_ua});
            rd_chk(7'h12);
        end
        for (i = 0; i < 2; i++)
        begin
            conv(16'($random(seed)));
            rd_chk(7'h18);
            host.wr(7'h18, 8'h5a);
            rd_chk(7'h1a);
            rd_chk(7'h1e);
            rd_chk(7'h1b);
            rd_chk(7'h18);
            rd_chk(7'h1b);
            rd_chk(7'h1e);
        end
        for (i = 0; i < 4; i++)
        begin
            f = {$random(seed)} % 6;
            l = f + {$random(seed)} % (7 - f);
            scan = {i[1:0] ^ 2'h2, l[2:0], f[2:0]};
            host.wr_scan(8'(scan));
            pend = 1;
            host.wr(7'h1f, 8'h00);
            rd_chk(7'h1f);
            rd_chk(7'h1e);
            for (j = 0; j < 9; j++)
                conv(16'($random(seed)));
        end
        scan = 8'h98;
        host.wr_scan(8'h98);
        @(posedge sys_clk);
        #1;
        apply();
        out_chk();
        for (i = 0; i < 2; i++)
        begin
            rd_chk(7'h1f);
            host.wr(7'h1f, i ? 8'h87 : 8'h7a);
            rd_chk(7'h1f);
        end
        repeat (5) conv(16'($random(seed)));
        summarize();
    end
endmodule
